// [hdl/error_flag_bank.sv]
// Purpose: sticky error flags and the interrupt status, enable and line
// Assumes: event inputs are one-cycle pulses
// Notes:   a set in the clear cycle wins
`timescale 1ns/1ps
`include "motor_status_consts.svh"
module error_flag_bank (
	// clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     rstn_i,
	// events
	input  wire motor_status_pkg::irq_vec_t event_i,
	// software access
	input  wire logic                     clear_wr_i,
	input  wire logic                     enable_wr_i,
	input  wire motor_status_pkg::irq_vec_t wdata_i,
	// state out
	output motor_status_pkg::irq_vec_t    sticky_o,
	output motor_status_pkg::irq_vec_t    status_o,
	output motor_status_pkg::irq_vec_t    enable_o,
	output logic                          irq_o
);

	// per-source flags
	for (genvar i = 0; i < `IRQ_COUNT; i++) begin : g_src
		always_ff @(posedge clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				sticky_o[i] <= 1'b0;
			end else if (event_i[i]) begin
				sticky_o[i] <= 1'b1;
			end
		end
		// interrupt status, set beats clear
		always_ff @(posedge clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				status_o[i] <= 1'b0;
			end else if (event_i[i]) begin
				status_o[i] <= 1'b1;
			end else if (clear_wr_i && wdata_i[i]) begin
				status_o[i] <= 1'b0;
			end
		end
	end

	// enable register
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			enable_o <= 4'h0;
		end else if (enable_wr_i) begin
			enable_o <= wdata_i;
		end
	end

	// level interrupt line
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(status_o & enable_o);
		end
	end

endmodule : error_flag_bank

// [hdl/motor_status_consts.svh]
// Purpose: offsets, codes, field positions and scaling for the status snapshot
// Assumes: 32-bit wishbone data, byte addresses, one word per register
// Notes:   definitions only
`ifndef MOTOR_STATUS_CONSTS_SVH
`define MOTOR_STATUS_CONSTS_SVH

// winding power state codes
`define PWR_UNKNOWN      8'h00
`define PWR_DISCONNECTED 8'h01
`define PWR_NOMINAL      8'h03
`define PWR_REDUCED      8'h04
`define PWR_MAXIMUM      8'h05
// current level select on the driver input
`define LVL_NOMINAL      2'h0
`define LVL_REDUCED      2'h1
`define LVL_MAXIMUM      2'h2

// encoder health codes
`define ENC_MISSING      8'h00
`define ENC_UNDETERMINED 8'h01
`define ENC_FAULTY       8'h02
`define ENC_REVERSED     8'h03
`define ENC_HEALTHY      8'h04

// winding health nibble codes, coil a low nibble, coil b upper nibble
`define COIL_ABSENT      4'h0
`define COIL_UNKNOWN     4'h1
`define COIL_SHORTED     4'h2
`define COIL_HEALTHY     4'h3

// state flag word
`define FLAG_CONTR_MASK  32'h0000_003f
`define FLAG_CMD_ERR     32'h0000_0001
`define FLAG_INTEG_ERR   32'h0000_0002
`define FLAG_VALUE_ERR   32'h0000_0004
`define FLAG_MEM_PRESENT 32'h0000_0010

// scaling: millivolts per reported count, temperature input fraction bits
`define MV_PER_COUNT     19'h0_000a
`define TENTHS_PER_DEG   20'h0_000a
`define TEMP_FRAC_BITS   4

// register byte offsets
`define OFS_CTRL         8'h00
`define OFS_CODES        8'h04
`define OFS_POSITION     8'h08
`define OFS_POS_FRAC     8'h0c
`define OFS_ENC_LO       8'h10
`define OFS_ENC_HI       8'h14
`define OFS_SPEED        8'h18
`define OFS_SPEED_FRAC   8'h1c
`define OFS_SUPPLY_V     8'h20
`define OFS_USB_V        8'h24
`define OFS_TEMP         8'h28
`define OFS_FLAGS        8'h2c
`define OFS_IRQ_STATUS   8'h30
`define OFS_IRQ_CLEAR    8'h34
`define OFS_IRQ_ENABLE   8'h38
`define OFS_SNAP_COUNT   8'h3c

// control register fields and reset
`define CTRL_CAPTURE_BIT 0
`define CTRL_AUTO_BIT    1
`define CTRL_RESET       2'h0

// interrupt sources
`define IRQ_COUNT        4
`define IRQ_CMD_BIT      0
`define IRQ_INTEG_BIT    1
`define IRQ_VALUE_BIT    2
`define IRQ_SNAP_BIT     3

`endif

// [hdl/motor_status_pkg.sv]
// Purpose: shared types of the status snapshot block
// Assumes: nothing
// Notes:   constants live in motor_status_consts.svh
package motor_status_pkg;

	typedef logic [7:0]  code_t;
	typedef logic [3:0]  irq_vec_t;
	typedef logic [31:0] word_t;

endpackage : motor_status_pkg

// [hdl/motor_status_snapshot.sv]
// Purpose: motor controller status snapshot behind a classic wishbone slave
// Assumes: all status inputs synchronous to clk_i; error inputs are pulses
// Notes:   ack one cycle after the request; status field reads return the last snapshot
//          auto capture pauses while a bus cycle is open
//
// The address map and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "motor_status_consts.svh"
module motor_status_snapshot (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// interrupt
	output logic             irq_o,
	// winding power
	input  wire logic        drv_connected_i,
	input  wire logic [1:0]  current_level_i,
	// encoder
	input  wire logic        enc_present_i,
	input  wire logic        enc_known_i,
	input  wire logic        enc_fault_i,
	input  wire logic        enc_reversed_i,
	// windings
	input  wire logic        coil_a_present_i,
	input  wire logic        coil_a_known_i,
	input  wire logic        coil_a_short_i,
	input  wire logic        coil_b_present_i,
	input  wire logic        coil_b_known_i,
	input  wire logic        coil_b_short_i,
	// motion
	input  wire logic [31:0] whole_step_position_i,
	input  wire logic [15:0] fractional_position_i,
	input  wire logic [63:0] encoder_count_position_i,
	input  wire logic [31:0] shaft_speed_i,
	input  wire logic [15:0] fractional_speed_i,
	// measurements
	input  wire logic [18:0] supply_mv_i,
	input  wire logic [18:0] usb_mv_i,
	input  wire logic [15:0] temperature_raw_i,
	// controller conditions
	input  wire logic        command_error_i,
	input  wire logic        integrity_error_i,
	input  wire logic        value_error_i,
	input  wire logic        settings_mem_present_i
);

	snap_if snap ();

	motor_status_pkg::code_t    winding_power_state;
	motor_status_pkg::code_t    encoder_health;
	motor_status_pkg::code_t    winding_health;
	logic                [3:0]  first_coil_code;
	logic                [3:0]  second_coil_code;
	motor_status_pkg::word_t    live_flags;
	motor_status_pkg::irq_vec_t events;
	motor_status_pkg::irq_vec_t sticky;
	motor_status_pkg::irq_vec_t irq_status;
	motor_status_pkg::irq_vec_t irq_enable;
	logic                [1:0]  ctrl_reg;
	logic                [31:0] snap_count_reg;
	logic                [31:0] rdata_next;
	logic                       bus_req;
	logic                       bus_wr;
	logic                       capture;
	logic                       capture_cmd;
	logic                       capture_auto;
	logic                       ctrl_wr;
	logic                       clear_wr;
	logic                       enable_wr;

	// a held request is not taken again while its ack stands
	assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr    = bus_req && wb_we_i && wb_sel_i[0];

	// write strobes per register, lane 0 carries every writable bit
	assign ctrl_wr   = bus_wr && (wb_adr_i == `OFS_CTRL);
	assign clear_wr  = bus_wr && (wb_adr_i == `OFS_IRQ_CLEAR);
	assign enable_wr = bus_wr && (wb_adr_i == `OFS_IRQ_ENABLE);

	// capture on a control write with the capture bit set
	assign capture_cmd  = ctrl_wr && wb_dat_i[`CTRL_CAPTURE_BIT];

	// auto mode waits for an idle bus, so a read never sees fields move
	assign capture_auto = ctrl_reg[`CTRL_AUTO_BIT] && !wb_cyc_i;

	// either source latches every field together
	assign capture      = capture_cmd || capture_auto;

	// winding power state
	always_comb begin
		if (!drv_connected_i) begin
			winding_power_state = `PWR_DISCONNECTED;
		end else begin
			unique case (current_level_i)
				`LVL_NOMINAL: winding_power_state = `PWR_NOMINAL;
				`LVL_REDUCED: winding_power_state = `PWR_REDUCED;
				`LVL_MAXIMUM: winding_power_state = `PWR_MAXIMUM;
				default:      winding_power_state = `PWR_UNKNOWN;
			endcase
		end
	end

	// encoder health
	always_comb begin
		if (!enc_present_i) begin
			encoder_health = `ENC_MISSING;
		end else if (!enc_known_i) begin
			encoder_health = `ENC_UNDETERMINED;
		end else if (enc_fault_i) begin
			encoder_health = `ENC_FAULTY;
		end else if (enc_reversed_i) begin
			encoder_health = `ENC_REVERSED;
		end else begin
			encoder_health = `ENC_HEALTHY;
		end
	end

	always_comb begin
		if (!coil_a_known_i) begin
			first_coil_code = `COIL_UNKNOWN;
		end else if (!coil_a_present_i) begin
			first_coil_code = `COIL_ABSENT;
		end else if (coil_a_short_i) begin
			first_coil_code = `COIL_SHORTED;
		end else begin
			first_coil_code = `COIL_HEALTHY;
		end
	end

	always_comb begin
		if (!coil_b_known_i) begin
			second_coil_code = `COIL_UNKNOWN;
		end else if (!coil_b_present_i) begin
			second_coil_code = `COIL_ABSENT;
		end else if (coil_b_short_i) begin
			second_coil_code = `COIL_SHORTED;
		end else begin
			second_coil_code = `COIL_HEALTHY;
		end
	end

	assign winding_health = {second_coil_code, first_coil_code};

	// error events and snapshot completion
	assign events = {snap.done, value_error_i, integrity_error_i, command_error_i};

	always_comb begin
		live_flags = 32'h0000_0000;
		if (sticky[`IRQ_CMD_BIT]) begin
			live_flags = live_flags | `FLAG_CMD_ERR;
		end
		if (sticky[`IRQ_INTEG_BIT]) begin
			live_flags = live_flags | `FLAG_INTEG_ERR;
		end
		if (sticky[`IRQ_VALUE_BIT]) begin
			live_flags = live_flags | `FLAG_VALUE_ERR;
		end
		if (settings_mem_present_i) begin
			live_flags = live_flags | `FLAG_MEM_PRESENT;
		end
		live_flags = live_flags & `FLAG_CONTR_MASK;
	end

	// snapshot latch
	// one shared capture strobe
	snapshot_capture u_capture (
		.clk_i        (clk_i),
		.rstn_i       (rstn_i),
		.capture_i    (capture),
		.power_code_i (winding_power_state),
		.enc_code_i   (encoder_health),
		.wind_code_i  (winding_health),
		.position_i   (whole_step_position_i),
		.pos_frac_i   (fractional_position_i),
		.enc_pos_i    (encoder_count_position_i),
		.speed_i      (shaft_speed_i),
		.speed_frac_i (fractional_speed_i),
		.supply_mv_i  (supply_mv_i),
		.usb_mv_i     (usb_mv_i),
		.temp_raw_i   (temperature_raw_i),
		.flags_i      (live_flags),
		.snap         (snap.producer)
	);

	// sticky flags and interrupt line
	// sticky until reset
	error_flag_bank u_flags (
		.clk_i       (clk_i),
		.rstn_i      (rstn_i),
		.event_i     (events),
		.clear_wr_i  (clear_wr),
		.enable_wr_i (enable_wr),
		.wdata_i     (wb_dat_i[3:0]),
		.sticky_o    (sticky),
		.status_o    (irq_status),
		.enable_o    (irq_enable),
		.irq_o       (irq_o)
	);

	// control register
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl_reg <= `CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_reg <= {wb_dat_i[`CTRL_AUTO_BIT], 1'b0};
		end
	end

	// snapshot counter
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			snap_count_reg <= 32'h0000_0000;
		end else if (snap.done) begin
			snap_count_reg <= snap_count_reg + 32'h0000_0001;
		end
	end

	// read data select, unmapped reads zero
	always_comb begin
		unique case (wb_adr_i)
			`OFS_CTRL:       rdata_next = {30'h0000_0000, ctrl_reg};
			`OFS_CODES:      rdata_next = {8'h00, snap.winding, snap.encoder, snap.power};
			`OFS_POSITION:   rdata_next = snap.position;
			`OFS_POS_FRAC:   rdata_next = {{16{snap.pos_frac[15]}}, snap.pos_frac};
			`OFS_ENC_LO:     rdata_next = snap.enc_pos[31:0];
			`OFS_ENC_HI:     rdata_next = snap.enc_pos[63:32];
			`OFS_SPEED:      rdata_next = snap.speed;
			`OFS_SPEED_FRAC: rdata_next = {{16{snap.speed_frac[15]}}, snap.speed_frac};
			`OFS_SUPPLY_V:   rdata_next = {16'h0000, snap.supply};
			`OFS_USB_V:      rdata_next = {16'h0000, snap.usb};
			`OFS_TEMP:       rdata_next = {{16{snap.temp[15]}}, snap.temp};
			`OFS_FLAGS:      rdata_next = snap.flags;
			`OFS_IRQ_STATUS: rdata_next = {28'h000_0000, irq_status};
			`OFS_IRQ_ENABLE: rdata_next = {28'h000_0000, irq_enable};
			`OFS_SNAP_COUNT: rdata_next = snap_count_reg;
			default:         rdata_next = 32'h0000_0000;
		endcase
	end

	// registered read data
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_req && !wb_we_i) begin
			wb_dat_o <= rdata_next;
		end
	end

	// ack one cycle after the request, dropped the next cycle
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

endmodule : motor_status_snapshot

// [hdl/snap_if.sv]
// Purpose: carries one captured status snapshot between blocks
// Assumes: single clock domain
// Notes:   producer writes all fields together
`timescale 1ns/1ps
interface snap_if;
	motor_status_pkg::code_t power;
	motor_status_pkg::code_t encoder;
	motor_status_pkg::code_t winding;
	logic [31:0]             position;
	logic [15:0]             pos_frac;
	logic [63:0]             enc_pos;
	logic [31:0]             speed;
	logic [15:0]             speed_frac;
	logic [15:0]             supply;
	logic [15:0]             usb;
	logic [15:0]             temp;
	logic [31:0]             flags;
	logic                    done;

	modport producer (output power, encoder, winding, position, pos_frac, enc_pos,
		speed, speed_frac, supply, usb, temp, flags, done);
	modport consumer (input power, encoder, winding, position, pos_frac, enc_pos,
		speed, speed_frac, supply, usb, temp, flags, done);
endinterface : snap_if

// [hdl/snapshot_capture.sv]
// Purpose: scales live readings, latches them with the encoded codes on one edge
// Assumes: inputs synchronous to clk_i
// Notes:   done pulses one cycle after each capture
`timescale 1ns/1ps
`include "motor_status_consts.svh"
module snapshot_capture (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	// capture request
	input  wire logic         capture_i,
	// encoded codes and live values
	input  wire logic [7:0]   power_code_i,
	input  wire logic [7:0]   enc_code_i,
	input  wire logic [7:0]   wind_code_i,
	input  wire logic [31:0]  position_i,
	input  wire logic [15:0]  pos_frac_i,
	input  wire logic [63:0]  enc_pos_i,
	input  wire logic [31:0]  speed_i,
	input  wire logic [15:0]  speed_frac_i,
	input  wire logic [18:0]  supply_mv_i,
	input  wire logic [18:0]  usb_mv_i,
	input  wire logic [15:0]  temp_raw_i,
	input  wire logic [31:0]  flags_i,
	// snapshot out
	snap_if.producer          snap
);

	logic signed [19:0] temp_x10;

	// temperature to tenths of a degree
	assign temp_x10 = 20'(signed'(temp_raw_i)) * signed'(`TENTHS_PER_DEG);

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			snap.power      <= `PWR_UNKNOWN;
			snap.encoder    <= `ENC_MISSING;
			snap.winding    <= 8'h00;
			snap.position   <= 32'h0000_0000;
			snap.pos_frac   <= 16'h0000;
			snap.enc_pos    <= 64'h0000_0000_0000_0000;
			snap.speed      <= 32'h0000_0000;
			snap.speed_frac <= 16'h0000;
			snap.supply     <= 16'h0000;
			snap.usb        <= 16'h0000;
			snap.temp       <= 16'h0000;
			snap.flags      <= 32'h0000_0000;
		end else if (capture_i) begin
			snap.power      <= power_code_i;
			snap.encoder    <= enc_code_i;
			snap.winding    <= wind_code_i;
			snap.position   <= position_i;
			snap.pos_frac   <= pos_frac_i;
			snap.enc_pos    <= enc_pos_i;
			snap.speed      <= speed_i;
			snap.speed_frac <= speed_frac_i;
			snap.supply     <= 16'(supply_mv_i / `MV_PER_COUNT);
			snap.usb        <= 16'(usb_mv_i / `MV_PER_COUNT);
			snap.temp       <= temp_x10[19:`TEMP_FRAC_BITS];
			snap.flags      <= flags_i;
		end
	end

	// completion pulse
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			snap.done <= 1'b0;
		end else begin
			snap.done <= capture_i;
		end
	end

endmodule : snapshot_capture

// [sim/host_wb_model.sv]
// Purpose: host side bus master issuing status requests
// Assumes: classic single cycle wishbone
// Notes:   late is set when no ack comes within the bound
`timescale 1ns/1ps
module host_wb_model (
	// clock
	input  wire logic        clk_i,
	// bus master side
	output logic             wb_cyc_o,
	output logic             wb_stb_o,
	output logic             wb_we_o,
	output logic [7:0]       wb_adr_o,
	output logic [3:0]       wb_sel_o,
	output logic [31:0]      wb_dat_o,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic        wb_ack_i
);
	// idle bus at time zero
	initial begin
		wb_cyc_o = 1'b0;
		wb_stb_o = 1'b0;
		wb_we_o  = 1'b0;
		wb_adr_o = 8'h00;
		wb_sel_o = 4'h0;
		wb_dat_o = 32'h0000_0000;
	end

	// one transfer, held until the edge that samples ack
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
		output logic [31:0] rdat, output logic late);
		late = 1'b1;
		rdat = 32'h0000_0000;
		@(posedge clk_i);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o  <= we;
		wb_adr_o <= adr;
		wb_sel_o <= 4'hf;
		wb_dat_o <= wdat;
		for (int n = 0; n < 64; n++) begin
			@(posedge clk_i);
			if (wb_ack_i === 1'b1) begin
				rdat = wb_dat_i;
				late = 1'b0;
				break;
			end
		end
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		wb_we_o  <= 1'b0;
		wb_dat_o <= ~wdat;
	endtask : xfer
endmodule : host_wb_model

// [sim/motor_status_snapshot_sva.sv]
// Purpose: port level checks of the status snapshot block
// Assumes: classic wishbone master, one request at a time
// Notes:   bound into every motor_status_snapshot
`timescale 1ns/1ps
`include "motor_status_consts.svh"
module motor_status_snapshot_sva (
	// clock, reset, bus and interrupt
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_o,
	input  wire logic        wb_ack_o,
	input  wire logic        irq_o
);
	logic rd_ack;
	logic codes_rd;
	logic flags_rd;
	logic en_seen_reg;
	logic cmd_seen_reg;

	// completed reads by place
	assign rd_ack   = wb_ack_o && wb_cyc_i && !wb_we_i;
	assign codes_rd = rd_ack && wb_adr_i == `OFS_CODES;
	assign flags_rd = rd_ack && wb_adr_i == `OFS_FLAGS;

	// an enable write was requested at least once
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) en_seen_reg <= 1'b0;
		else if (wb_cyc_i && wb_we_i && wb_adr_i == `OFS_IRQ_ENABLE) en_seen_reg <= 1'b1;
	end

	// a command error was once seen in the flag word
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) cmd_seen_reg <= 1'b0;
		else if (flags_rd && wb_dat_o[0]) cmd_seen_reg <= 1'b1;
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	ack_follows_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	dat_hold_a: assert property ($changed(wb_dat_o) |-> rd_ack)
		else $error("read data moved outside a read");
	unmapped_zero_a: assert property (rd_ack && wb_adr_i >= 8'h40 |-> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	irq_quiet_a: assert property (!en_seen_reg |-> !irq_o)
		else $error("interrupt with nothing enabled");
	power_code_a: assert property (codes_rd |-> wb_dat_o[7:0] inside {8'h00, 8'h01, 8'h03, 8'h04, 8'h05})
		else $error("illegal power code");
	enc_code_a: assert property (codes_rd |-> wb_dat_o[15:8] <= 8'h04)
		else $error("illegal encoder code");
	coil_code_a: assert property (codes_rd |-> wb_dat_o[19:18] == 2'h0 && wb_dat_o[23:22] == 2'h0)
		else $error("illegal coil code");
	flag_group_a: assert property (flags_rd |-> (wb_dat_o & 32'hffff_ffe8) == 32'h0000_0000)
		else $error("flag bits outside the group");
	flag_sticky_a: assert property (flags_rd && cmd_seen_reg |-> wb_dat_o[0])
		else $error("command error flag lost");

	cover property (codes_rd);
	cover property (flags_rd && wb_dat_o[0]);
	cover property ($rose(irq_o));
endmodule : motor_status_snapshot_sva

bind motor_status_snapshot motor_status_snapshot_sva i_sva (.clk_i(clk_i), .rstn_i(rstn_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));

// [sim/tb_top.sv]
// Purpose: self checking bench of the status snapshot block
// Assumes: host model drives the bus
// Notes:   expectations worked out from the field encodings
`timescale 1ns/1ps
`include "motor_status_consts.svh"
module tb_top;
	logic        clk, rstn, cyc, stb, we, ack, irq, drv, mem;
	logic [7:0]  adr;
	logic [3:0]  sel, enc;
	logic [2:0]  ca, cb, errs;
	logic [1:0]  lvl;
	logic [31:0] wdat, rdat, pos, spd;
	logic [15:0] pfr, sfr, traw;
	logic [63:0] encp;
	logic [18:0] smv, umv;
	int          failures, total_checks;

	host_wb_model i_host (.clk_i(clk), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
		.wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat), .wb_dat_i(rdat), .wb_ack_i(ack));

	motor_status_snapshot i_dut (.clk_i(clk), .rstn_i(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .irq_o(irq), .drv_connected_i(drv), .current_level_i(lvl),
		.enc_present_i(enc[0]), .enc_known_i(enc[1]), .enc_fault_i(enc[2]),
		.enc_reversed_i(enc[3]), .coil_a_present_i(ca[0]), .coil_a_known_i(ca[1]),
		.coil_a_short_i(ca[2]), .coil_b_present_i(cb[0]), .coil_b_known_i(cb[1]),
		.coil_b_short_i(cb[2]), .whole_step_position_i(pos), .fractional_position_i(pfr),
		.encoder_count_position_i(encp), .shaft_speed_i(spd), .fractional_speed_i(sfr),
		.supply_mv_i(smv), .usb_mv_i(umv), .temperature_raw_i(traw),
		.command_error_i(errs[0]), .integrity_error_i(errs[1]), .value_error_i(errs[2]),
		.settings_mem_present_i(mem));

	task automatic test_done;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : test_done

	task automatic check(input logic [31:0] exp, got, input string what);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		logic late;
		i_host.xfer(w, a, d, q, late);
		if (late) begin
			failures++;
			$display("Error ack expected 1 seen 0");
			test_done();
		end
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask : wr

	task automatic expect_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0000_0000, q);
		check(exp, q, what);
	endtask : expect_rd

	task automatic pulse(input logic [2:0] e);
		@(posedge clk) errs <= e;
		@(posedge clk) errs <= 3'h0;
	endtask : pulse

	// reset values after release
	task automatic t_reset;
		expect_rd(`OFS_CODES, 32'h0000_0000, "codes");
		expect_rd(`OFS_FLAGS, 32'h0000_0000, "flags");
		expect_rd(`OFS_IRQ_ENABLE, 32'h0000_0000, "enable");
		expect_rd(`OFS_SNAP_COUNT, 32'h0000_0000, "count");
		check(32'h0000_0000, {31'h0, irq}, "irq");
	endtask : t_reset

	// every power, encoder and coil code with priority cases
	task automatic t_codes;
		logic [7:0] pwr [5] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h00};
		logic [3:0] ein [5] = '{4'b1110, 4'b1101, 4'b1111, 4'b1011, 4'b0011};
		logic [2:0] cin [4] = '{3'b110, 3'b101, 3'b111, 3'b011};
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			drv <= (i != 0);
			lvl <= 2'(i - 1);
			enc <= ein[i];
			ca  <= cin[i % 4];
			cb  <= cin[(i + 2) % 4];
			wr(`OFS_CTRL, 32'h0000_0001);
			expect_rd(`OFS_CODES, {10'h0, 2'((i + 2) % 4), 2'h0, 2'(i % 4), 8'(i), pwr[i]},
				"codes");
		end
	endtask : t_codes

	// frozen motion fields and scaled readings
	task automatic t_motion;
		logic [7:0]  ofs [10] = '{`OFS_POSITION, `OFS_POS_FRAC, `OFS_ENC_LO, `OFS_ENC_HI,
			`OFS_SPEED, `OFS_SPEED_FRAC, `OFS_SUPPLY_V, `OFS_USB_V, `OFS_TEMP, `OFS_CODES};
		logic [31:0] exp [10] = '{32'h8000_0001, 32'hffff_ff80, 32'h9abc_def0, 32'h1234_5678,
			32'hffff_fff6, 32'h0000_0040, 32'h0000_04d2, 32'h0000_01f4, 32'hffff_fff0,
			32'h0020_0400};
		@(posedge clk);
		{pos, pfr, encp} <= {32'h8000_0001, 16'hff80, 64'h1234_5678_9abc_def0};
		{spd, sfr, smv, umv, traw} <= {32'hffff_fff6, 16'h0040, 19'h0_3039, 19'h0_1391, 16'hffe7};
		wr(`OFS_CTRL, 32'h0000_0001);
		@(posedge clk);
		{pos, pfr, encp, spd, sfr} <= ~{pos, pfr, encp, spd, sfr};
		{smv, umv, traw, enc, ca} <= {19'h7_ffff, 19'h0_0009, 16'h0190, 4'h0, 3'h0};
		for (int i = 0; i < 10; i++) expect_rd(ofs[i], exp[i], "field");
		wr(`OFS_CTRL, 32'h0000_0001);
		expect_rd(`OFS_SUPPLY_V, 32'h0000_cccc, "supply");
		expect_rd(`OFS_USB_V, 32'h0000_0000, "usb");
		expect_rd(`OFS_TEMP, 32'h0000_00fa, "temp");
	endtask : t_motion

	// error flags and memory presence
	task automatic t_flags;
		@(posedge clk) mem <= 1'b1;
		wr(`OFS_CTRL, 32'h0000_0001);
		expect_rd(`OFS_FLAGS, 32'h0000_0010, "flags");
		pulse(3'b001);
		wr(`OFS_CTRL, 32'h0000_0001);
		expect_rd(`OFS_FLAGS, 32'h0000_0011, "flags");
		pulse(3'b110);
		@(posedge clk) mem <= 1'b0;
		wr(`OFS_CTRL, 32'h0000_0001);
		expect_rd(`OFS_FLAGS, 32'h0000_0007, "flags");
		repeat (5) @(posedge clk);
		wr(`OFS_CTRL, 32'h0000_0001);
		expect_rd(`OFS_FLAGS, 32'h0000_0007, "flags");
	endtask : t_flags

	// raise, mask and clear the interrupt; unmapped place
	task automatic t_irq;
		wr(`OFS_IRQ_CLEAR, 32'h0000_000f);
		expect_rd(`OFS_IRQ_STATUS, 32'h0000_0000, "status");
		wr(`OFS_IRQ_ENABLE, 32'h0000_0005);
		expect_rd(`OFS_IRQ_ENABLE, 32'h0000_0005, "enable");
		pulse(3'b001);
		pulse(3'b010);
		repeat (3) @(posedge clk);
		check(32'h0000_0001, {31'h0, irq}, "irq");
		expect_rd(`OFS_IRQ_STATUS, 32'h0000_0003, "status");
		wr(`OFS_IRQ_CLEAR, 32'h0000_0001);
		repeat (3) @(posedge clk);
		check(32'h0000_0000, {31'h0, irq}, "irq");
		wr(`OFS_IRQ_ENABLE, 32'h0000_0002);
		repeat (3) @(posedge clk);
		check(32'h0000_0001, {31'h0, irq}, "irq");
		wr(`OFS_IRQ_CLEAR, 32'h0000_000f);
		wr(`OFS_CTRL, 32'h0000_0001);
		expect_rd(`OFS_IRQ_STATUS, 32'h0000_0008, "status");
		expect_rd(`OFS_SNAP_COUNT, 32'h0000_000c, "count");
		wr(8'h40, 32'hffff_ffff);
		expect_rd(8'h40, 32'h0000_0000, "unmapped");
	endtask : t_irq

	// auto capture follows live inputs while idle and freezes once stopped
	task automatic t_auto;
		wr(`OFS_CTRL, 32'h0000_0002);
		@(posedge clk) pos <= 32'h1357_9bdf;
		repeat (2) @(posedge clk);
		expect_rd(`OFS_CTRL, 32'h0000_0002, "ctrl");
		expect_rd(`OFS_POSITION, 32'h1357_9bdf, "position");
		wr(`OFS_CTRL, 32'h0000_0000);
		@(posedge clk) pos <= 32'h0000_0000;
		repeat (2) @(posedge clk);
		expect_rd(`OFS_POSITION, 32'h1357_9bdf, "position");
	endtask : t_auto

	// free running clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// reset then scenarios in order
	initial begin
		{rstn, drv, mem, enc, ca, cb, errs, lvl} = '0;
		{pos, spd, pfr, sfr, traw, encp, smv, umv} = '0;
		failures = 0;
		total_checks = 0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_codes();
		t_motion();
		t_flags();
		t_irq();
		t_auto();
		test_done();
	end
endmodule : tb_top
